/* File: reset_monitor_map.svh */
`ifndef RESET_MONITOR_MAP_SVH
`define RESET_MONITOR_MAP_SVH

// ==========================================================
// Clock
`define RM_CLK_PERIOD_NS    20

// ==========================================================
// Timing (least times, rounded up to whole cycles)
`define RM_POR_DELAY_NS     1000000
`define RM_POR_DELAY_CYC    ((`RM_POR_DELAY_NS + `RM_CLK_PERIOD_NS - 1) / `RM_CLK_PERIOD_NS)
`define RM_MON_RELEASE_NS   100000
`define RM_MON_RELEASE_CYC  ((`RM_MON_RELEASE_NS + `RM_CLK_PERIOD_NS - 1) / `RM_CLK_PERIOD_NS)
`define RM_SRC_HOLD_NS      400
`define RM_SRC_HOLD_CYC     ((`RM_SRC_HOLD_NS + `RM_CLK_PERIOD_NS - 1) / `RM_CLK_PERIOD_NS)

// ==========================================================
// Widths and limits
`define RM_CNT_W            17
`define RM_LVL12_MAX        3'h4
`define RM_LVL_W            3
`define RM_DIV_W            4

`endif

/* File: reset_monitor_pkg.sv */
package reset_monitor_pkg;

    // ==========================================================
    // Edge selection for monitor events
    typedef enum logic [1:0] {
        EDGE_RISE,
        EDGE_FALL,
        EDGE_BOTH,
        EDGE_NONE
    } edge_sel_t;

    // ==========================================================
    // Per-monitor release state
    typedef enum logic [1:0] {
        MON_IDLE,
        MON_HELD,
        MON_RELEASE
    } mon_state_t;

    // ==========================================================
    // Configuration of monitors 1 and 2
    typedef struct packed {
        logic       enable;
        logic [2:0] level;
        logic       filt_en;
        logic [1:0] div_sel;
        edge_sel_t  edge_sel;
        logic       irq_mode;
        logic       nmi_sel;
        logic       release_sel;
    } mon_cfg_t;

    // ==========================================================
    // Reset cause flags
    typedef struct packed {
        logic software;
        logic periph_wdt;
        logic indep_wdt;
        logic deep_standby;
        logic mon2;
        logic mon1;
        logic mon0;
        logic por;
        logic pin;
    } reset_cause_t;

endpackage : reset_monitor_pkg

/* File: reset_source_and_voltage_monitor.sv */
// Summary of operation
// RQ1 - External reset pin held low forces the internal reset.
// RQ2 - Supply rising with the pin high starts a power-on reset.
// RQ3 - Power-on reset holds until supply is good plus a fixed delay.
// RQ4 - Each of monitors zero to two can raise its own falling-supply reset.
// RQ5 - Deep-standby release request raises a reset.
// RQ6 - Independent watchdog underflow or refresh error raises a reset.
// RQ7 - Peripheral watchdog underflow or refresh error raises a reset.
// RQ8 - Software reset request raises a reset.
// RQ9 - Monitor zero reset is enabled by an option-memory setting.
// RQ10 - Monitor zero offers one of two detection levels.
// RQ11 - Monitors one and two offer five levels and optional reset.
// RQ12 - Monitors one and two filtered at slow oscillator over 2, 4, 8, 16.
// RQ13 - Two selectable release timings for monitors one and two; monitor zero releases after recovery.
// RQ14 - A monitor may raise an interrupt instead of a reset.
// RQ15 - Rising, falling or both edges selectable per monitor.
// RQ16 - Monitor interrupt routed as maskable or non-maskable per monitor.
// RQ17 - Cause of the most recent reset kept in readable flags.
`timescale 1ns/1ps
`include "reset_monitor_map.svh"

module reset_source_and_voltage_monitor #(
    parameter int CW      = `RM_CNT_W,
    parameter int POR_CYC = `RM_POR_DELAY_CYC,
    parameter int REL_CYC = `RM_MON_RELEASE_CYC,
    parameter int HLD_CYC = `RM_SRC_HOLD_CYC
) (
    input  wire logic                            sys_clk_in,
    input  wire logic                            sys_rst_in,
    input  wire logic                            external_reset_pin_n_in,
    input  wire logic                            supply_por_ok_in,
    input  wire logic [2:0]                      supply_voltage_detector_in,
    input  wire logic                            low_speed_osc_tick_in,
    input  wire logic                            deep_standby_wake_in,
    input  wire logic                            independent_watchdog_underflow_in,
    input  wire logic                            independent_watchdog_refresh_err_in,
    input  wire logic                            peripheral_watchdog_underflow_in,
    input  wire logic                            peripheral_watchdog_refresh_err_in,
    input  wire logic                            sw_reset_req_in,
    input  wire logic                            mon0_reset_en_in,
    input  wire logic                            mon0_level_sel_in,
    input  wire reset_monitor_pkg::mon_cfg_t [1:0] mon_cfg_in,
    input  wire logic                            cause_clear_in,
    output logic                                 internal_reset_out,
    output reset_monitor_pkg::reset_cause_t      reset_cause_out,
    output logic                                 mon0_level_out,
    output logic [1:0][2:0]                      mon_level_out,
    output logic [1:0]                           mon_filtered_out,
    output logic [1:0]                           mon_irq_out,
    output logic [1:0]                           mon_nmi_out
);
    import reset_monitor_pkg::*;

    // ==========================================================
    // State
    typedef struct packed {
        logic                         rst;
        reset_cause_t                 cause;
        logic [CW-1:0]                por_cnt;
        logic                         por_done;
        logic [CW-1:0]                hold_cnt;
        mon_state_t [2:0]             mst;
        logic [2:0][CW-1:0]           mcnt;
        logic [1:0][`RM_DIV_W-1:0]    div;
        logic [1:0]                   smp;
        logic [1:0]                   filt;
        logic [1:0]                   prev;
        logic [1:0]                   irq;
        logic [1:0]                   nmi;
        logic                         lvl0;
        logic [1:0][`RM_LVL_W-1:0]    lvl;
    } state_t;

    localparam logic [CW-1:0] POR_LAST = CW'(POR_CYC - 1);
    localparam logic [CW-1:0] REL_LAST = CW'(REL_CYC - 1);
    localparam logic [CW-1:0] HLD_LOAD = CW'(HLD_CYC);

    state_t st_ff;
    state_t nxt_st;

    // ==========================================================
    // Divider tap: sample point for /2, /4, /8, /16
    function automatic logic div_hit(input logic [`RM_DIV_W-1:0] cnt,
                                     input logic [1:0]           sel);
        logic [`RM_DIV_W-1:0] mask;
        case (sel)
            2'h0:    mask = 4'h1;
            2'h1:    mask = 4'h3;
            2'h2:    mask = 4'h7;
            default: mask = 4'hf;
        endcase
        return (cnt & mask) == mask;
    endfunction : div_hit

    // ==========================================================
    // Next state
    always_comb begin
        reset_cause_t src;
        logic [2:0]   low;
        logic [2:0]   rel_sel;
        logic         raw;
        logic         ev;
        logic         pulse;
        src     = '0;
        low     = '0;
        rel_sel = '0;
        raw     = 1'b0;
        ev      = 1'b0;
        pulse   = 1'b0;
        nxt_st  = st_ff;

        // Power-on delay restarts whenever the supply dips again
        if (!supply_por_ok_in) begin
            nxt_st.por_cnt  = '0;                                     // [RQ3]
            nxt_st.por_done = 1'b0;
        end else if (!st_ff.por_done) begin
            if (st_ff.por_cnt == POR_LAST) begin
                nxt_st.por_done = 1'b1;                               // [RQ3]
            end else begin
                nxt_st.por_cnt = st_ff.por_cnt + 1'b1;
            end
        end

        // Monitors 1 and 2: filter, edge detect, interrupt routing
        for (int i = 0; i < 2; i++) begin
            raw = supply_voltage_detector_in[i+1];
            if (low_speed_osc_tick_in) begin
                nxt_st.div[i] = st_ff.div[i] + 1'b1;
                if (div_hit(st_ff.div[i], mon_cfg_in[i].div_sel)) begin  // [RQ12]
                    nxt_st.smp[i] = raw;
                    // Two matching samples needed, rejects single glitches
                    if (raw == st_ff.smp[i]) begin
                        nxt_st.filt[i] = raw;                         // [RQ12]
                    end
                end
            end
            if (!mon_cfg_in[i].filt_en) begin
                nxt_st.filt[i] = raw;
                nxt_st.smp[i]  = raw;
            end
            nxt_st.prev[i] = st_ff.filt[i];
            case (mon_cfg_in[i].edge_sel)                             // [RQ15]
                EDGE_RISE: ev = st_ff.filt[i] & ~st_ff.prev[i];
                EDGE_FALL: ev = ~st_ff.filt[i] & st_ff.prev[i];
                EDGE_BOTH: ev = st_ff.filt[i] ^ st_ff.prev[i];
                default:   ev = 1'b0;
            endcase
            ev = ev & mon_cfg_in[i].enable & mon_cfg_in[i].irq_mode;  // [RQ14]
            nxt_st.irq[i] = ev & ~mon_cfg_in[i].nmi_sel;              // [RQ16]
            nxt_st.nmi[i] = ev & mon_cfg_in[i].nmi_sel;               // [RQ16]
            nxt_st.lvl[i] = (mon_cfg_in[i].level > `RM_LVL12_MAX) ?   // [RQ11]
                            `RM_LVL12_MAX : mon_cfg_in[i].level;
            low[i+1]      = mon_cfg_in[i].enable & ~mon_cfg_in[i].irq_mode &
                            ~st_ff.filt[i];                           // [RQ11]
            rel_sel[i+1]  = mon_cfg_in[i].release_sel;
        end
        nxt_st.lvl0 = mon0_level_sel_in;                              // [RQ10]
        low[0]      = mon0_reset_en_in & ~supply_voltage_detector_in[0];  // [RQ9]

        // Monitor resets: release after recovery, or after detection
        for (int m = 0; m < 3; m++) begin
            case (st_ff.mst[m])                                       // [RQ13]
                MON_IDLE: begin
                    if (low[m]) begin
                        nxt_st.mst[m]  = MON_HELD;                    // [RQ4]
                        nxt_st.mcnt[m] = '0;
                    end
                end
                MON_HELD: begin
                    if (rel_sel[m]) begin
                        nxt_st.mcnt[m] = st_ff.mcnt[m] + 1'b1;
                        if (st_ff.mcnt[m] == REL_LAST) begin
                            nxt_st.mst[m] = MON_IDLE;
                        end
                    end else if (!low[m]) begin
                        nxt_st.mst[m]  = MON_RELEASE;
                        nxt_st.mcnt[m] = '0;
                    end
                end
                MON_RELEASE: begin
                    if (low[m]) begin
                        nxt_st.mst[m] = MON_HELD;
                    end else if (st_ff.mcnt[m] == REL_LAST) begin
                        nxt_st.mst[m] = MON_IDLE;
                    end else begin
                        nxt_st.mcnt[m] = st_ff.mcnt[m] + 1'b1;
                    end
                end
                default: nxt_st.mst[m] = MON_IDLE;
            endcase
        end

        // Source collection
        src.pin          = ~external_reset_pin_n_in;                  // [RQ1]
        src.por          = ~st_ff.por_done & external_reset_pin_n_in; // [RQ2]
        src.mon0         = low[0] | (st_ff.mst[0] != MON_IDLE);       // [RQ4]
        src.mon1         = low[1] | (st_ff.mst[1] != MON_IDLE);       // [RQ4]
        src.mon2         = low[2] | (st_ff.mst[2] != MON_IDLE);       // [RQ4]
        src.deep_standby = deep_standby_wake_in;                      // [RQ5]
        src.indep_wdt    = independent_watchdog_underflow_in |
                           independent_watchdog_refresh_err_in;       // [RQ6]
        src.periph_wdt   = peripheral_watchdog_underflow_in |
                           peripheral_watchdog_refresh_err_in;        // [RQ7]
        src.software     = sw_reset_req_in;                           // [RQ8]

        // Pulse sources are stretched so the reset has a usable width
        pulse = src.deep_standby | src.indep_wdt | src.periph_wdt | src.software;
        if (pulse) begin
            nxt_st.hold_cnt = HLD_LOAD;
        end else if (st_ff.hold_cnt != '0) begin
            nxt_st.hold_cnt = st_ff.hold_cnt - 1'b1;
        end

        // A new reset replaces old flags; set always beats clear
        if ((src != '0) && !st_ff.rst) begin
            nxt_st.cause = src;                                       // [RQ17]
        end else begin
            nxt_st.cause = (cause_clear_in ? reset_cause_t'('0) : st_ff.cause) | src;
        end

        nxt_st.rst = (src != '0) | (st_ff.hold_cnt != '0);
    end

    // ==========================================================
    // Registers
    always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_ff           <= '0;
            st_ff.rst       <= 1'b1;
            st_ff.cause.por <= 1'b1;
            // Supply assumed good so no false falling edge after reset
            st_ff.smp       <= 2'h3;
            st_ff.filt      <= 2'h3;
            st_ff.prev      <= 2'h3;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign internal_reset_out = st_ff.rst;
    assign reset_cause_out    = st_ff.cause;
    assign mon0_level_out     = st_ff.lvl0;
    assign mon_level_out      = st_ff.lvl;
    assign mon_filtered_out   = st_ff.filt;
    assign mon_irq_out        = st_ff.irq;
    assign mon_nmi_out        = st_ff.nmi;

    // ==========================================================
    // Checks
    pin_reset_a: assert property (                                    // [RQ1]
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        !external_reset_pin_n_in |=> internal_reset_out && reset_cause_out.pin)
        else $error("pin low did not force reset");

    por_hold_a: assert property (                                     // [RQ3]
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (!supply_por_ok_in && external_reset_pin_n_in) |=>
            !st_ff.por_done ##1 internal_reset_out)
        else $error("power-on reset released with supply low");

    por_delay_a: assert property (                                    // [RQ3]
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        $rose(st_ff.por_done) |-> $past(supply_por_ok_in) &&
            ($past(st_ff.por_cnt) == POR_LAST))
        else $error("power-on delay ended early");

    deep_standby_a: assert property (                                 // [RQ5]
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        deep_standby_wake_in |=> internal_reset_out && reset_cause_out.deep_standby)
        else $error("deep standby release gave no reset");

    indep_wdt_a: assert property (                                    // [RQ6]
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (independent_watchdog_underflow_in || independent_watchdog_refresh_err_in)
            |=> internal_reset_out && reset_cause_out.indep_wdt)
        else $error("independent watchdog gave no reset");

    periph_wdt_a: assert property (                                   // [RQ7]
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (peripheral_watchdog_underflow_in || peripheral_watchdog_refresh_err_in)
            |=> internal_reset_out && reset_cause_out.periph_wdt)
        else $error("peripheral watchdog gave no reset");

    sw_reset_a: assert property (                                     // [RQ8]
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        sw_reset_req_in |=> internal_reset_out [*2])
        else $error("software reset not held two cycles");

    mon0_enable_a: assert property (                                  // [RQ9]
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (!mon0_reset_en_in && st_ff.mst[0] == MON_IDLE) |=>
            st_ff.mst[0] == MON_IDLE)
        else $error("monitor zero reset while disabled");

    irq_route_a: assert property (                                    // [RQ16]
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        mon_irq_out[0] |-> !mon_nmi_out[0] && !$past(mon_cfg_in[0].nmi_sel))
        else $error("maskable interrupt with nmi selected");

    irq_mode_a: assert property (                                     // [RQ14]
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (mon_irq_out[1] || mon_nmi_out[1]) |-> $past(mon_cfg_in[1].irq_mode) &&
            $past(mon_cfg_in[1].enable))
        else $error("monitor interrupt outside interrupt mode");

    level_clamp_a: assert property (                                  // [RQ11]
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        mon_level_out[0] <= `RM_LVL12_MAX && mon_level_out[1] <= `RM_LVL12_MAX)
        else $error("level select beyond five levels");

    mon_reset_a: assert property (                                    // [RQ4]
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (st_ff.mst[2] != MON_IDLE) |=> internal_reset_out && reset_cause_out.mon2)
        else $error("monitor two held without reset");

    filter_hold_a: assert property (                                  // [RQ12]
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (mon_cfg_in[0].filt_en && !low_speed_osc_tick_in) |=> $stable(mon_filtered_out[0]))
        else $error("filtered level moved between samples");

    edge_rise_a: assert property (                                    // [RQ15]
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        ($rose(mon_filtered_out[0]) && mon_cfg_in[0].enable && mon_cfg_in[0].irq_mode &&
            !mon_cfg_in[0].nmi_sel && mon_cfg_in[0].edge_sel == EDGE_RISE) |=> mon_irq_out[0])
        else $error("rising edge gave no interrupt");

    edge_none_a: assert property (                                    // [RQ15]
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (mon_cfg_in[0].edge_sel == EDGE_NONE) |=> !mon_irq_out[0] && !mon_nmi_out[0])
        else $error("events raised with no edge selected");

    release_time_a: assert property (                                 // [RQ13]
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (st_ff.mst[2] == MON_HELD && mon_cfg_in[1].release_sel && st_ff.mcnt[2] == REL_LAST)
            |=> st_ff.mst[2] == MON_IDLE)
        else $error("detection-timed release overran");

    cause_replace_a: assert property (                                // [RQ17]
        @(posedge sys_clk_in) disable iff (sys_rst_in)
        (!internal_reset_out && sw_reset_req_in && !peripheral_watchdog_underflow_in &&
            !peripheral_watchdog_refresh_err_in) |=> reset_cause_out.software &&
            !reset_cause_out.periph_wdt)
        else $error("new reset kept stale cause flags");

endmodule : reset_source_and_voltage_monitor

/* File: supply_partner_model.sv */
`timescale 1ns/1ps

module supply_partner_model (
    input  wire logic            sys_clk_in,
    input  wire logic [3:0]      supply_in,
    input  wire logic            mon0_level_in,
    input  wire logic [1:0][2:0] mon_level_in,
    output logic                 por_ok_out,
    output logic [2:0]           detector_out,
    output logic                 tick_out
);
    logic [1:0] div_ff = 2'h0;

    // ==========================================
    // Slow oscillator: one enable every fourth clock
    initial tick_out = 1'b0;
    always @(posedge sys_clk_in) begin
        div_ff   <= div_ff + 2'h1;
        tick_out <= (div_ff == 2'h3);
    end

    // ==========================================
    // Comparators: supply against the selected level
    always_comb begin
        por_ok_out      = (supply_in != 4'h0);
        detector_out[0] = supply_in > (4'h4 + {3'h0, mon0_level_in});
        detector_out[1] = supply_in > (4'h2 + {1'h0, mon_level_in[0]});
        detector_out[2] = supply_in > (4'h2 + {1'h0, mon_level_in[1]});
    end
endmodule : supply_partner_model

/* File: tb_top.sv */
`timescale 1ns/1ps

module tb_top;
    import reset_monitor_pkg::*;

    typedef struct packed {
        logic [6:0] src;
        logic [8:0] cause;
        logic [4:0] lo;
        logic [4:0] hi;
    } row_t;

    // ==========================================
    // Sources: pin, standby, watchdogs, software
    localparam row_t ROWS [7] = '{
        '{7'h01, 9'h001, 5'h0, 5'h3},
        '{7'h02, 9'h020, 5'h11, 5'h16},
        '{7'h04, 9'h040, 5'h11, 5'h16},
        '{7'h08, 9'h040, 5'h11, 5'h16},
        '{7'h10, 9'h080, 5'h11, 5'h16},
        '{7'h20, 9'h080, 5'h11, 5'h16},
        '{7'h40, 9'h100, 5'h11, 5'h16}
    };

    logic            clk;
    logic            rst;
    logic [3:0]      supply;
    logic [6:0]      src;
    logic            mon0_en;
    logic            mon0_sel;
    logic            clr;
    mon_cfg_t [1:0]  cfg;
    logic            por_ok;
    logic [2:0]      det;
    logic            tick;
    logic            rst_out;
    reset_cause_t    cause;
    logic            lvl0;
    logic [1:0][2:0] lvl;
    logic [1:0]      filt;
    logic [1:0]      irq;
    logic [1:0]      nmi;
    int              err_total = 0;
    int              cmp_count = 0;
    int              n;
    int              c_irq;
    int              c_nmi;
    logic            seen;

    supply_partner_model supply_partner_model_i (
        .sys_clk_in(clk), .supply_in(supply), .mon0_level_in(lvl0),
        .mon_level_in(lvl), .por_ok_out(por_ok), .detector_out(det), .tick_out(tick));

    // Short counts keep the run brief
    reset_source_and_voltage_monitor #(.POR_CYC(8), .REL_CYC(8))
        reset_source_and_voltage_monitor_i (
        .sys_clk_in(clk), .sys_rst_in(rst), .external_reset_pin_n_in(~src[0]),
        .supply_por_ok_in(por_ok), .supply_voltage_detector_in(det),
        .low_speed_osc_tick_in(tick), .deep_standby_wake_in(src[1]),
        .independent_watchdog_underflow_in(src[2]),
        .independent_watchdog_refresh_err_in(src[3]),
        .peripheral_watchdog_underflow_in(src[4]),
        .peripheral_watchdog_refresh_err_in(src[5]), .sw_reset_req_in(src[6]),
        .mon0_reset_en_in(mon0_en), .mon0_level_sel_in(mon0_sel), .mon_cfg_in(cfg),
        .cause_clear_in(clr), .internal_reset_out(rst_out), .reset_cause_out(cause),
        .mon0_level_out(lvl0), .mon_level_out(lvl), .mon_filtered_out(filt),
        .mon_irq_out(irq), .mon_nmi_out(nmi));

    // ==========================================
    // Helpers
    task automatic check(input string name, input logic [8:0] exp, input logic [8:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic hold_till(input logic v, input int lim);
        n = 0;
        #1;
        while (rst_out !== v && n < lim) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask : hold_till

    function automatic mon_cfg_t mk_cfg(input logic im, input logic nm, input logic rs,
                                        input logic [2:0] lv, input logic [1:0] dv,
                                        input edge_sel_t es);
        mk_cfg = '{1'b1, lv, 1'b1, dv, es, im, nm, rs};
    endfunction : mk_cfg

    // Low half then high half; the filter at /16 needs the long window
    task automatic run_events(input int m, input logic [3:0] low);
        c_irq = 0;
        c_nmi = 0;
        seen = 1'b0;
        for (int i = 0; i < 400; i++) begin
            @(posedge clk);
            if (i == 0) supply <= low;
            if (i == 200) supply <= 4'hf;
            #1;
            c_irq += int'(irq[m] === 1'b1);
            c_nmi += int'(nmi[m] === 1'b1);
            seen |= (rst_out === 1'b1);
            if (i == 199) check("filtered level", 9'h0, {8'h0, filt[m]});
        end
    endtask : run_events

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize

    // ==========================================
    // Clock and watchdog
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    initial begin
        repeat (8000) @(posedge clk);
        err_total++;
        $display("unexpected run length expected 8000 seen more");
        summarize();
    end

    // ==========================================
    // Main sequence
    initial begin
        rst = 1'b1;
        supply = 4'hf;
        src = 7'h0;
        mon0_en = 1'b0;
        mon0_sel = 1'b0;
        clr = 1'b0;
        cfg = '0;
        repeat (10) @(posedge clk);
        #1;
        check("reset in reset", 9'h1, {8'h0, rst_out});
        check("cause in reset", 9'h002, cause);
        @(posedge clk);
        rst <= 1'b0;
        hold_till(1'b0, 40);
        check("power-on span", 9'h1, {8'h0, n >= 8 && n <= 12});
        @(posedge clk);
        supply <= 4'h0;
        @(posedge clk);
        supply <= 4'hf;
        hold_till(1'b1, 5);
        hold_till(1'b0, 40);
        check("supply dip span", 9'h1, {8'h0, n >= 7 && n <= 13});
        check("dip cause", 9'h002, cause);
        foreach (ROWS[r]) begin
            @(posedge clk);
            src <= ROWS[r].src;
            @(posedge clk);
            src <= 7'h0;
            #1;
            check("reset level", 9'h1, {8'h0, rst_out});
            check("cause flags", ROWS[r].cause, cause);
            hold_till(1'b0, 40);
            check("hold span", 9'h1, {8'h0, n >= ROWS[r].lo && n <= ROWS[r].hi});
        end
        @(posedge clk);
        mon0_en <= 1'b1;
        mon0_sel <= 1'b1;
        supply <= 4'h5;
        hold_till(1'b1, 10);
        check("monitor 0 level", 9'h1, {8'h0, lvl0});
        check("monitor 0 cause", 9'h004, cause);
        @(posedge clk);
        supply <= 4'hf;
        hold_till(1'b0, 40);
        check("release span", 9'h1, {8'h0, n >= 8 && n <= 14});
        @(posedge clk);
        mon0_en <= 1'b0;
        supply <= 4'h5;
        repeat (10) @(posedge clk);
        #1;
        check("monitor 0 disabled", 9'h0, {8'h0, rst_out});
        for (int e = 0; e < 4; e++) begin
            @(posedge clk);
            cfg[0] <= mk_cfg(1'b1, 1'b0, 1'b0, 3'h7, 2'(e), edge_sel_t'(e));
            run_events(0, 4'h5);
            check("irq count", (e == 2) ? 9'h2 : (e == 3) ? 9'h0 : 9'h1, 9'(c_irq));
            check("no reset in irq mode", 9'h0, {8'h0, seen});
        end
        check("level clamp", 9'h4, {6'h0, lvl[0]});
        @(posedge clk);
        cfg[0] <= '0;
        cfg[1] <= mk_cfg(1'b0, 1'b0, 1'b1, 3'h0, 2'h0, EDGE_FALL);
        run_events(1, 4'h1);
        check("monitor 2 reset", 9'h1, {8'h0, seen});
        check("monitor 2 cause", 9'h010, cause);
        check("monitor 2 released", 9'h0, {8'h0, rst_out});
        @(posedge clk);
        cfg[1] <= mk_cfg(1'b1, 1'b1, 1'b0, 3'h0, 2'h0, EDGE_FALL);
        run_events(1, 4'h1);
        check("nmi count", 9'h1, 9'(c_nmi));
        check("maskable count", 9'h0, 9'(c_irq));
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        #1;
        check("cleared cause", 9'h000, cause);
        summarize();
    end
endmodule : tb_top
